// [rtl/tca_pkg.sv]
// package: shared constants, register map and carrier types
package tca_pkg;
   // ==========================================================
   // register map (byte addresses on classic wishbone)
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_SLOT0  = 8'h04;
   localparam logic [7:0] ADDR_WIDTH  = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_TXDATA = 8'h1C;
   localparam logic [7:0] ADDR_RXDATA = 8'h20;
   localparam logic [7:0] SLOT_STRIDE = 8'h04;
   // config register fields
   localparam int CFG_MODE_LO   = 0;
   localparam int CFG_DOUBLE    = 2;
   localparam int CFG_OPEN_DRN  = 3;
   localparam int CFG_GROUP_SEL = 4;
   localparam int CFG_FRAME_512 = 5;
   // reset values
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
   localparam logic [7:0]  SLOT_RST   = 8'h00;
   // frame and slot constants
   localparam logic [9:0] FRAME_256   = 10'h0FF;
   localparam logic [9:0] FRAME_512   = 10'h1FF;
   localparam logic [9:0] BUS_CH_BITS = 10'h020;
   localparam logic [9:0] BUS_D_OFS   = 10'h01A;
   localparam logic [9:0] BUS_GRP_OFS = 10'h080;
   localparam logic [3:0] BUS_WIDTH   = 4'h2;

   // ==========================================================
   // operating modes
   typedef enum logic [1:0] {
      TCA_SINGLE_SLOT = 2'b00,
      TCA_QUAD_STROBE = 2'b01,
      TCA_SINGLE_BUS  = 2'b10,
      TCA_QUAD_SLOT   = 2'b11
   } tca_mode_t;

   // configuration carrier
   typedef struct packed {
      logic       frame_512;
      logic       bus_channel_group_sel;
      logic       open_drain;
      logic       double_rate;
      tca_mode_t  mode;
   } tca_cfg_t;

   // one bit moving to or from a controller
   typedef struct packed {
      logic [1:0] chan;
      logic       bit_val;
   } tca_bit_t;
endpackage

// [rtl/tca_fifo.sv]
// file: parameterised valid/ready fifo
module tca_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 16
) (
   input  wire logic             i_clock,
   input  wire logic             i_reset,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   // ==========================================================
   // pointer update
   assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem_r[rd_r];
   assign push = i_in_valid && o_in_ready;
   assign pop  = o_out_valid && i_out_ready;

   always_comb begin
      wr_nxt  = push ? wr_r + AW'(1) : wr_r;
      rd_nxt  = pop ? rd_r + AW'(1) : rd_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   // storage has no reset; only pointers matter
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_r[wr_r] <= i_in_data;
      end
      if (i_reset) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// [rtl/tca_top.sv]
// file: serial channel access unit with wishbone registers
// Function
// R1: sample rx on falling, drive tx rising
// R2: clock equals or doubles data rate
// R3: tx released outside assigned slot
// R4: two-bit mode field selects four modes
// R5: single modes share line 0, quad own
// R6: 8-bit slot position, two-bit granularity
// R7: slot width 1, 2, 7 or 8
// R8: counters wrap at 256/512 frame end
// R9: other frame lengths need sync each frame
// R10: bus mode fixed two-bit slots, open-drain
// R11: tristate control push-pull, strobe inverted
// R12: quad slot mode marks controller B
// R13: push-pull or open-drain selectable
// R14: strobe mode transfers while sync high
// R15: single slot mode marks any controller
// R16: group select picks bus channels 0-3/4-7
// R17: slot start is twice position value
module tca_top (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_serial_bit_clock,
   input  wire logic        i_frame_sync,
   input  wire logic [3:0]  i_serial_rx,
   output logic      [3:0]  o_serial_tx,
   output logic      [3:0]  o_serial_tx_oe,
   output logic             o_tristate_control_n
);
   // ==========================================================
   // registers
   tca_pkg::tca_cfg_t cfg_r, cfg_nxt;
   logic [7:0]  slot_position_reg_r [4];
   logic [7:0]  slot_pos_nxt [4];
   logic [7:0]  width_r, width_nxt;   // two bits per controller
   logic [3:0]  tx_bits_r, tx_bits_nxt;
   logic [3:0]  rx_new_r, rx_new_nxt;
   logic [31:0] rdat_nxt;
   logic        ack_r, ack_nxt;
   logic        wr_hit, rd_fifo;

   // ==========================================================
   // pin synchronisers
   logic [5:0] sync1_r, sync2_r;
   logic       clk_d_r, clk_d_nxt;
   logic       rise, fall, shift_en;
   logic       half_r, half_nxt;

   // first stage feeds only the second
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {i_frame_sync, i_serial_bit_clock, i_serial_rx};
         sync2_r <= sync1_r;
      end
   end

   // edge detect on the synchronised bit clock
   assign clk_d_nxt = sync2_r[4];
   assign rise = sync2_r[4] && !clk_d_r;  // [R1]
   assign fall = !sync2_r[4] && clk_d_r;  // [R1]
   // in double rate mode only every other falling edge shifts
   assign half_nxt = fall ? ~half_r : half_r;
   assign shift_en = fall && (!cfg_r.double_rate || half_r);  // [R2]

   // ==========================================================
   // bit counter and frame alignment
   logic [9:0] bit_cnt_r, bit_cnt_nxt;
   logic       fs_d_r;
   logic [9:0] frame_end;

   assign frame_end = cfg_r.frame_512 ? tca_pkg::FRAME_512
                                      : tca_pkg::FRAME_256;
   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      if (sync2_r[5] && !fs_d_r) begin
         bit_cnt_nxt = '0;  // [R9]
      end else if (shift_en) begin
         if (bit_cnt_r == frame_end) begin
            bit_cnt_nxt = '0;  // [R8]
         end else begin
            bit_cnt_nxt = bit_cnt_r + 10'h001;
         end
      end
   end

   // ==========================================================
   // per-controller slot windows
   logic [3:0] in_slot;
   tca_pkg::tca_mode_t mode;
   assign mode = cfg_r.mode;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_slot
         logic [9:0] start;
         logic [3:0] len;
         always_comb begin
            // width code 00/01/10/11 -> 1/2/7/8 bits
            case (width_r[2*g +: 2])  // [R7]
               2'b00:   len = 4'h1;
               2'b01:   len = 4'h2;
               2'b10:   len = 4'h7;
               default: len = 4'h8;
            endcase
            start = {1'b0, slot_position_reg_r[g], 1'b0};  // [R6] [R17]
            if (mode == tca_pkg::TCA_SINGLE_BUS) begin
               // d bits of bus channel g or g+4
               len   = tca_pkg::BUS_WIDTH;  // [R10]
               start = 10'(g) * tca_pkg::BUS_CH_BITS
                     + tca_pkg::BUS_D_OFS
                     + (cfg_r.bus_channel_group_sel ?
                        tca_pkg::BUS_GRP_OFS : 10'h000);  // [R16]
            end
         end
         always_comb begin
            if (mode == tca_pkg::TCA_QUAD_STROBE) begin
               in_slot[g] = sync2_r[5];  // [R14]
            end else begin
               in_slot[g] = (bit_cnt_r >= start)
                         && (bit_cnt_r < start + 10'(len));
            end
         end
      end
   endgenerate

   // ==========================================================
   // line routing and output drivers
   logic [3:0] tx_r, tx_nxt, oe_r, oe_nxt;
   logic       tsc_n_r, tsc_n_nxt;
   logic       quad;
   assign quad = mode[0];  // [R5]

   always_comb begin
      tx_nxt = tx_r;
      oe_nxt = oe_r;
      if (rise) begin
         tx_nxt = '1;
         oe_nxt = '0;
         for (int c = 0; c < 4; c++) begin
            if (in_slot[c]) begin
               // [R5] single modes drive line 0 only
               tx_nxt[quad ? c : 0] = tx_bits_r[c];
               oe_nxt[quad ? c : 0] =
                  !(cfg_r.open_drain || mode == tca_pkg::TCA_SINGLE_BUS)
                  || !tx_bits_r[c];  // [R3] [R10] [R13]
            end
         end
      end
   end

   // tristate control is a plain push-pull level; slot marks move on
   // the bit clock rise so they frame the driven bit, not the counter
   always_comb begin
      tsc_n_nxt = tsc_n_r;
      case (mode)  // [R4]
         tca_pkg::TCA_QUAD_STROBE: tsc_n_nxt = ~sync2_r[5];  // [R11]
         tca_pkg::TCA_QUAD_SLOT: begin
            if (rise) begin
               tsc_n_nxt = ~in_slot[1];  // [R12]
            end
         end
         default: begin
            if (rise) begin
               tsc_n_nxt = ~|in_slot;  // [R10] [R15]
            end
         end
      endcase
   end

   // ==========================================================
   // receive capture into the fifo
   logic       fifo_in_ready, fifo_out_valid, push;
   tca_pkg::tca_bit_t fifo_in, fifo_out;
   logic [1:0] rx_ch_r, rx_ch_nxt;
   logic       rx_pend_r, rx_pend_nxt;

   always_comb begin
      rx_new_nxt  = rx_new_r;
      rx_ch_nxt   = rx_ch_r;
      rx_pend_nxt = rx_pend_r;
      if (push) begin
         rx_new_nxt[rx_ch_r] = 1'b0;
      end
      if (shift_en) begin
         for (int c = 0; c < 4; c++) begin
            if (in_slot[c]) begin
               rx_new_nxt[c] = sync2_r[quad ? c : 0];  // [R1] [R5]
               rx_ch_nxt     = 2'(c);
               rx_pend_nxt   = 1'b1;
            end
         end
      end else if (push) begin
         rx_pend_nxt = 1'b0;
      end
   end
   assign push    = rx_pend_r && fifo_in_ready && !shift_en;
   assign fifo_in = '{chan: rx_ch_r, bit_val: rx_new_r[rx_ch_r]};

   tca_fifo #(
      .WIDTH ($bits(tca_pkg::tca_bit_t)),
      .DEPTH (16)
   ) u_fifo (
      .i_clock     (i_clock),
      .i_reset     (i_reset),
      .i_in_valid  (rx_pend_r && !shift_en),  // same gate as push
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (fifo_in),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (rd_fifo),
      .o_out_data  (fifo_out)
   );

   // ==========================================================
   // wishbone slave, one wait state, ack one cycle
   assign wr_hit  = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
   assign rd_fifo = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_r
                 && i_wb_adr == tca_pkg::ADDR_RXDATA;
   assign ack_nxt = i_wb_cyc && i_wb_stb && !ack_r;

   always_comb begin
      cfg_nxt      = cfg_r;
      width_nxt    = width_r;
      tx_bits_nxt  = tx_bits_r;
      slot_pos_nxt = slot_position_reg_r;
      rdat_nxt     = 32'h0000_0000;
      if (wr_hit && i_wb_sel[0]) begin
         case (i_wb_adr)
            tca_pkg::ADDR_CONFIG:
               cfg_nxt = tca_pkg::tca_cfg_t'(i_wb_dat[5:0]);
            tca_pkg::ADDR_WIDTH:  width_nxt = i_wb_dat[7:0];
            tca_pkg::ADDR_TXDATA: tx_bits_nxt = i_wb_dat[3:0];
            default: begin
               for (int c = 0; c < 4; c++) begin
                  if (i_wb_adr == tca_pkg::ADDR_SLOT0
                      + 8'(c) * tca_pkg::SLOT_STRIDE) begin
                     slot_pos_nxt[c] = i_wb_dat[7:0];
                  end
               end
            end
         endcase
      end
      case (i_wb_adr)
         tca_pkg::ADDR_CONFIG: rdat_nxt[5:0] = cfg_r;
         tca_pkg::ADDR_WIDTH:  rdat_nxt[7:0] = width_r;
         tca_pkg::ADDR_TXDATA: rdat_nxt[3:0] = tx_bits_r;
         tca_pkg::ADDR_STATUS: rdat_nxt[13:0] =
            {fifo_out_valid, bit_cnt_r, 1'b0, |in_slot,
             o_tristate_control_n};
         tca_pkg::ADDR_RXDATA: rdat_nxt[3:0] =
            {fifo_out_valid, fifo_out};
         default: begin
            for (int c = 0; c < 4; c++) begin
               if (i_wb_adr == tca_pkg::ADDR_SLOT0
                   + 8'(c) * tca_pkg::SLOT_STRIDE) begin
                  rdat_nxt[7:0] = slot_position_reg_r[c];
               end
            end
         end
      endcase
   end

   // ==========================================================
   // state registers
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         cfg_r       <= tca_pkg::tca_cfg_t'(tca_pkg::CONFIG_RST[5:0]);
         width_r     <= '0;
         tx_bits_r   <= '1;
         ack_r       <= 1'b0;
         o_wb_dat    <= '0;
         clk_d_r     <= 1'b0;
         half_r      <= 1'b0;
         fs_d_r      <= 1'b0;
         bit_cnt_r   <= '0;
         tx_r        <= '1;
         oe_r        <= '0;
         tsc_n_r     <= 1'b1;
         rx_new_r    <= '0;
         rx_ch_r     <= '0;
         rx_pend_r   <= 1'b0;
         for (int c = 0; c < 4; c++) begin
            slot_position_reg_r[c] <= tca_pkg::SLOT_RST;
         end
      end else begin
         cfg_r       <= cfg_nxt;
         width_r     <= width_nxt;
         tx_bits_r   <= tx_bits_nxt;
         ack_r       <= ack_nxt;
         o_wb_dat    <= rdat_nxt;
         clk_d_r     <= clk_d_nxt;
         half_r      <= half_nxt;
         fs_d_r      <= sync2_r[5];
         bit_cnt_r   <= bit_cnt_nxt;
         tx_r        <= tx_nxt;
         oe_r        <= oe_nxt;
         tsc_n_r     <= tsc_n_nxt;
         rx_new_r    <= rx_new_nxt;
         rx_ch_r     <= rx_ch_nxt;
         rx_pend_r   <= rx_pend_nxt;
         slot_position_reg_r <= slot_pos_nxt;
      end
   end

   assign o_wb_ack             = ack_r;
   assign o_serial_tx          = tx_r;
   assign o_serial_tx_oe       = oe_r;
   assign o_tristate_control_n = tsc_n_r;  // [R11]
endmodule

// [sim/tca_properties.sv]
// checker: port-level properties of the channel access unit
module tca_properties (
   input wire logic        i_clock,
   input wire logic        i_reset,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_serial_bit_clock,
   input wire logic        i_frame_sync,
   input wire logic [3:0]  i_serial_rx,
   input wire logic [3:0]  o_serial_tx,
   input wire logic [3:0]  o_serial_tx_oe,
   input wire logic        o_tristate_control_n
);
   // ==========================================================
   // shadow config; writes move outputs off the bit grid, so wait
   tca_pkg::tca_cfg_t cfg_r, cfg_nxt;
   // tx and oe follow a write only at the next bit clock rise: wait 15
   logic [3:0]        quiet_r, quiet_nxt;
   logic [2:0]        age_r, age_nxt;
   logic              bclk_r;
   logic              calm;
   assign calm = (quiet_r == 4'hF);
   always_comb begin
      cfg_nxt = cfg_r;
      quiet_nxt = calm ? quiet_r : quiet_r + 4'h1;
      age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
      if (o_wb_ack && i_wb_we)
         quiet_nxt = 4'h0;
      if (o_wb_ack && i_wb_we && i_wb_sel[0] &&
          i_wb_adr == tca_pkg::ADDR_CONFIG)
         cfg_nxt = tca_pkg::tca_cfg_t'(i_wb_dat[5:0]);
      if (i_serial_bit_clock && !bclk_r)
         age_nxt = 3'h0;
      if (i_reset) begin
         cfg_nxt = '0;
         quiet_nxt = 4'h0;
      end
   end
   always_ff @(posedge i_clock) begin
      cfg_r <= cfg_nxt;
      quiet_r <= quiet_nxt;
      age_r <= age_nxt;
      bclk_r <= i_serial_bit_clock;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
      |=> o_wb_ack) else $error("no ack after request");
   ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   tx_on_rise_a: assert property (calm && ($changed(o_serial_tx) ||
      $changed(o_serial_tx_oe)) |-> age_r inside {[3'h1:3'h5]})
      else $error("tx moved away from a bit clock rise");
   single_line0_a: assert property (calm && !cfg_r.mode[0]
      |-> o_serial_tx_oe[3:1] == 3'h0) else $error("line 1-3 driven");
   bus_open_drain_a: assert property (calm &&
      cfg_r.mode == tca_pkg::TCA_SINGLE_BUS
      |-> (o_serial_tx_oe & o_serial_tx) == 4'h0) else $error("bus high");
   od_select_a: assert property (calm && cfg_r.open_drain
      |-> (o_serial_tx_oe & o_serial_tx) == 4'h0) else $error("od high");
   strobe_tsc_a: assert property (calm && $rose(i_frame_sync) &&
      cfg_r.mode == tca_pkg::TCA_QUAD_STROBE
      |-> ##[2:6] !o_tristate_control_n) else $error("tsc not on strobe");
   quad_tsc_b_a: assert property (calm && !cfg_r.open_drain &&
      cfg_r.mode == tca_pkg::TCA_QUAD_SLOT
      |-> o_tristate_control_n == !o_serial_tx_oe[1]) else $error("tsc b");
   any_tsc_a: assert property (calm && !cfg_r.open_drain &&
      cfg_r.mode == tca_pkg::TCA_SINGLE_SLOT
      |-> o_tristate_control_n == !o_serial_tx_oe[0]) else $error("tsc");
   cover property (cfg_r.mode[0] && !cfg_r.mode[1] && !o_tristate_control_n);
   cover property (cfg_r.mode == tca_pkg::TCA_QUAD_SLOT && o_serial_tx_oe[1]);
   cover property (cfg_r.open_drain && o_serial_tx_oe[0]);
endmodule
bind tca_top tca_properties tca_properties_inst (.*);

// [sim/tca_highway.sv]
// partner: highway timing source with bit clock, sync and rx data
module tca_highway (
   input  wire logic       i_sync_en,
   input  wire logic       i_strobe,
   output logic            o_bit_clock,
   output logic            o_frame_sync,
   output logic      [3:0] o_rx
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // free running data clock, phase unrelated to the system clock
   logic [7:0] bit_n = 8'h00;
   initial begin
      o_bit_clock = 1'b0;
      o_frame_sync = 1'b0;
      o_rx = 4'h0;
      #137;
      forever #200 o_bit_clock = ~o_bit_clock;
   end
   // launch on the rise so lines are settled at the fall
   always @(posedge o_bit_clock) begin
      bit_n <= bit_n + 8'h01;
      o_frame_sync <= i_sync_en &&
         (bit_n + 8'h01 < (i_strobe ? 8'h10 : 8'h01));
      o_rx <= ~o_rx ^ bit_n[3:0]; // each line toggles where bit_n[3:0] is 0 and holds where it is 1
   end
endmodule

// [sim/tca_top_tb_top.sv]
// bench: register sequences and slot occupancy counts
module tca_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sync_en = 1'b1;
   logic        strobe = 1'b0, ack, bclk, fsync, tsc_n;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000, rd, rdat;
   logic [3:0]  rx, tx, oe;
   int          fails = 0, n_checks = 0, n_oe[4], n_tsc, k, n_zero;
   int          q_exp[4] = '{8, 16, 56, 64};
   always #25 i_clock = ~i_clock;
   tca_top tca_top_inst (.i_clock(i_clock), .i_reset(i_reset),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_serial_bit_clock(bclk), .i_frame_sync(fsync), .i_serial_rx(rx),
      .o_serial_tx(tx), .o_serial_tx_oe(oe), .o_tristate_control_n(tsc_n));
   tca_highway tca_highway_inst (.i_sync_en(sync_en), .i_strobe(strobe),
      .o_bit_clock(bclk), .o_frame_sync(fsync), .o_rx(rx));
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until the rising edge that sees ack, released there;
   // only the watchdog ends a wait
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge i_clock);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      check(nm, rd, exp);
   endtask
   // config write, then one frame to settle
   task automatic cfg(input logic od, dbl, gs, tca_pkg::tca_mode_t m);
      wb(1'b1, tca_pkg::ADDR_CONFIG, {26'h0, gs, od, dbl, m});
      repeat (2048) @(posedge i_clock);
   endtask
   // counts over a whole frame are independent of phase
   task automatic measure(input int n);
      n_tsc = 0;
      n_zero = 0;
      n_oe = '{0, 0, 0, 0};
      repeat (n) begin
         @(posedge i_clock);
         for (k = 0; k < 4; k++) n_oe[k] += (oe[k] === 1'b1);
         n_tsc += (tsc_n === 1'b0);
         n_zero += (oe[0] === 1'b1 && tx[0] === 1'b0);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #3000000;
      fails++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      @(posedge i_clock);
      check("idle pins", {tsc_n, oe, tx}, 9'h10F);
      rdchk("config", tca_pkg::ADDR_CONFIG, 32'h0000_0000);
      rdchk("tx bits", tca_pkg::ADDR_TXDATA, 32'h0000_000F);
      rdchk("unmapped", 8'hFC, 32'h0000_0000);
      // slots A..D start at bits 8, 16, 32, 64; widths 1, 2, 7, 8
      for (int i = 0; i < 4; i++)
         wb(1'b1, tca_pkg::ADDR_SLOT0 + tca_pkg::SLOT_STRIDE * i[7:0],
            32'h0000_0004 << i);
      wb(1'b1, tca_pkg::ADDR_WIDTH, 32'h0000_00E4);
      wb(1'b1, tca_pkg::ADDR_TXDATA, 32'h0000_0000);
      rdchk("width", tca_pkg::ADDR_WIDTH, 32'h0000_00E4);
      rdchk("slot d", 8'h10, 32'h0000_0020);
      cfg(1'b0, 1'b0, 1'b0, tca_pkg::TCA_SINGLE_SLOT);
      measure(2048);
      check("oe0 single", n_oe[0], 144);
      check("oe1 single", n_oe[1], 0);
      check("tsc single", n_tsc, 144);
      // no strobe: receive path frozen while the fifo is drained
      sync_en <= 1'b0;
      cfg(1'b0, 1'b0, 1'b0, tca_pkg::TCA_QUAD_STROBE);
      wb(1'b0, tca_pkg::ADDR_STATUS, 32'h0000_0000);
      check("fifo held", rd[13], 1'b1);
      n_tsc = 0;
      repeat (20) begin
         wb(1'b0, tca_pkg::ADDR_RXDATA, 32'h0000_0000);
         n_tsc += rd[3];
      end
      // sixteen stored plus the one bit held at the fifo input
      check("fifo depth", n_tsc, 17);
      wb(1'b0, tca_pkg::ADDR_STATUS, 32'h0000_0000);
      check("fifo empty", rd[13], 1'b0);
      strobe <= 1'b1;
      sync_en <= 1'b1;
      cfg(1'b0, 1'b0, 1'b0, tca_pkg::TCA_QUAD_STROBE);
      measure(2048);
      check("tsc strobe", n_tsc, 128);
      check("oe3 strobe", n_oe[3], 128);
      strobe <= 1'b0;
      cfg(1'b0, 1'b0, 1'b0, tca_pkg::TCA_QUAD_SLOT);
      measure(2048);
      for (int i = 0; i < 4; i++)
         check("oe quad", n_oe[i], q_exp[i]);
      check("tsc quad", n_tsc, 16);
      for (int g = 0; g < 2; g++) begin
         cfg(1'b0, 1'b0, g[0], tca_pkg::TCA_SINGLE_BUS);
         measure(2048);
         check("oe bus", n_oe[0], 64);
      end
      // open drain: only zeros of A and C are driven
      wb(1'b1, tca_pkg::ADDR_TXDATA, 32'h0000_000A);
      cfg(1'b1, 1'b0, 1'b0, tca_pkg::TCA_SINGLE_SLOT);
      measure(2048);
      check("oe od", n_oe[0], 64);
      // double rate without sync relies on the wrap at frame end
      sync_en <= 1'b0;
      cfg(1'b0, 1'b1, 1'b0, tca_pkg::TCA_SINGLE_SLOT);
      repeat (2048) @(posedge i_clock);
      measure(4096);
      check("oe double", n_oe[0], 288);
      check("tx0 double", n_zero, 128);
      // longer frame, still no sync: the counter must run to 511
      wb(1'b1, tca_pkg::ADDR_CONFIG,
         32'h0000_0001 << tca_pkg::CFG_FRAME_512);
      repeat (64) @(posedge i_clock);
      measure(4096);
      check("oe 512", n_oe[0], 144);
      summarize();
   end
endmodule
